// >>> pkg/fhc_regs.vh
// Summary of operation
// - Host never issues unassigned command codes such as 0x00.
// - Host polls the ready bit first, then evaluates failure bits; for the status op it reads once and evaluates without waiting for ready.
// - Host ignores supply-low bit while supply is in the uncertain band.
// - Host masks out reserved status bit 0 when polling.
// - Error bits are sticky; host clears them with code 0x50.
`ifndef FHC_REGS_VH
`define FHC_REGS_VH

// command codes
`define FHC_CMD_PROG_ALT    8'h10
`define FHC_CMD_ERASE_SETUP 8'h20
`define FHC_CMD_CONFIRM     8'hD0
`define FHC_CMD_SUSPEND     8'hB0
`define FHC_CMD_READ_STATUS 8'h70
`define FHC_CMD_CLEAR       8'h50

// user operations
`define FHC_OP_PROGRAM      3'h0
`define FHC_OP_ERASE        3'h1
`define FHC_OP_SUSPEND      3'h2
`define FHC_OP_RESUME       3'h3
`define FHC_OP_CLEAR        3'h4
`define FHC_OP_STATUS       3'h5

// status word bit positions
`define FHC_SB_READY        7
`define FHC_SB_ERASE_PAUSED 6
`define FHC_SB_ERASE_FAIL   5
`define FHC_SB_PROG_FAIL    4
`define FHC_SB_SUPPLY_LOW   3
`define FHC_SB_PROG_PAUSED  2
`define FHC_SB_LOCK_ABORT   1
`define FHC_SB_RESERVED     0
`define FHC_STATUS_MASK     8'hFE

// timing
`define FHC_CLK_NS          100
`define FHC_T_ACC_NS        70
`define FHC_ACC_CYC         ((`FHC_T_ACC_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_SYNC_CYC        2
`define FHC_RD_CYC          (`FHC_ACC_CYC + `FHC_SYNC_CYC)

`endif

// >>> hw/fhc_host.v
`timescale 1ns/10ps
`default_nettype none
`include "fhc_regs.vh"
module fhc_host (
  // clock and reset
  input  wire        I_CLK,
  input  wire        I_RST,
  // user command port
  input  wire        i_cmd_valid,
  input  wire [2:0]  i_cmd_op,
  input  wire [21:0] i_cmd_addr,
  input  wire [15:0] i_cmd_data,
  output wire        o_cmd_ready,
  // user result port
  output reg         o_done,
  output reg         o_cmd_bad,
  output reg  [7:0]  o_status,
  output reg         o_prog_fail,
  output reg         o_erase_fail,
  output reg         o_supply_low,
  output reg         o_lock_abort,
  output reg         o_seq_err,
  output reg         o_prog_paused,
  output reg         o_erase_paused,
  // system supply monitor
  input  wire        i_supply_marginal,
  // flash pins
  output reg  [21:0] o_flash_addr,
  output reg  [15:0] o_flash_dq_out,
  output reg         o_flash_dq_oe,
  input  wire [15:0] i_flash_dq,
  output reg         o_flash_ce_n,
  output reg         o_flash_oe_n,
  output reg         o_flash_we_n,
  output reg         o_flash_rst_n
);

  // controller states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WRITE = 3'h1;
  localparam [2:0] ST_READ  = 3'h2;
  localparam [2:0] ST_EVAL  = 3'h3;
  localparam [2:0] ST_DONE  = 3'h4;
  // status-read strobe length, in clocks
  localparam [31:0] RD_CYC   = `FHC_RD_CYC;
  localparam [1:0]  RD_LAST  = RD_CYC[1:0];

  // latched request and synchronised pins
  reg  [2:0]  state_r;
  reg  [1:0]  phase_r;
  reg  [1:0]  rd_cnt_r;
  reg  [2:0]  op_r;
  reg         second_r;
  reg  [15:0] data_r;
  reg  [15:0] dq_meta_r;
  reg  [15:0] dq_sync_r;
  reg         marg_meta1_r;
  reg         marg_sync_r;
  wire [7:0]  stat_w;

  // user handshake and masked status
  assign o_cmd_ready = (state_r == ST_IDLE) && o_flash_rst_n;
  assign stat_w      = dq_sync_r[7:0] & `FHC_STATUS_MASK;

  // true when op needs a second bus write
  function two_writes;
    input [2:0] op;
    begin
      two_writes = (op == `FHC_OP_PROGRAM) || (op == `FHC_OP_ERASE);
    end
  endfunction

  // first command code of an op
  function [7:0] first_code;
    input [2:0] op;
    begin
      case (op)
        `FHC_OP_PROGRAM: first_code = `FHC_CMD_PROG_ALT;
        `FHC_OP_ERASE:   first_code = `FHC_CMD_ERASE_SETUP;
        `FHC_OP_SUSPEND: first_code = `FHC_CMD_SUSPEND;
        `FHC_OP_RESUME:  first_code = `FHC_CMD_CONFIRM;
        `FHC_OP_CLEAR:   first_code = `FHC_CMD_CLEAR;
        default:         first_code = `FHC_CMD_READ_STATUS;
      endcase
    end
  endfunction

  // command-sequence error pattern of a status word
  function seq_error;
    input [7:0] s;
    begin
      seq_error = s[`FHC_SB_READY] & s[`FHC_SB_PROG_FAIL] & s[`FHC_SB_ERASE_FAIL];
    end
  endfunction

  // input synchronisers
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      dq_meta_r    <= 16'h0000;
      dq_sync_r    <= 16'h0000;
      marg_meta1_r <= 1'b0;
      marg_sync_r  <= 1'b0;
    end else begin
      dq_meta_r    <= i_flash_dq;
      dq_sync_r    <= dq_meta_r;
      marg_meta1_r <= i_supply_marginal;
      marg_sync_r  <= marg_meta1_r;
    end
  end

  // bus sequencing and result capture
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r        <= ST_IDLE;
      phase_r        <= 2'h0;
      rd_cnt_r       <= 2'h0;
      op_r           <= 3'h0;
      second_r       <= 1'b0;
      data_r         <= 16'h0000;
      o_done         <= 1'b0;
      o_cmd_bad      <= 1'b0;
      o_status       <= 8'h00;
      o_prog_fail    <= 1'b0;
      o_erase_fail   <= 1'b0;
      o_supply_low   <= 1'b0;
      o_lock_abort   <= 1'b0;
      o_seq_err      <= 1'b0;
      o_prog_paused  <= 1'b0;
      o_erase_paused <= 1'b0;
      o_flash_addr   <= 22'h000000;
      o_flash_dq_out <= 16'h0000;
      o_flash_dq_oe  <= 1'b0;
      o_flash_ce_n   <= 1'b1;
      o_flash_oe_n   <= 1'b1;
      o_flash_we_n   <= 1'b1;
      o_flash_rst_n  <= 1'b0;
    end else begin
      o_flash_rst_n <= 1'b1;
      o_done        <= 1'b0;
      o_cmd_bad     <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (i_cmd_valid && o_flash_rst_n) begin
            if (i_cmd_op > `FHC_OP_STATUS) begin
              o_cmd_bad <= 1'b1;
              o_done    <= 1'b1;
            end else begin
              op_r           <= i_cmd_op;
              second_r       <= 1'b0;
              data_r         <= i_cmd_data;
              o_flash_addr   <= i_cmd_addr;
              o_flash_dq_out <= {8'h00, first_code(i_cmd_op)};
              phase_r        <= 2'h0;
              state_r        <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          phase_r <= phase_r + 2'h1;
          case (phase_r)
            2'h0: begin
              o_flash_ce_n  <= 1'b0;
              o_flash_dq_oe <= 1'b1;
            end
            2'h1: o_flash_we_n <= 1'b0;
            2'h2: o_flash_we_n <= 1'b1;
            default: begin
              o_flash_ce_n  <= 1'b1;
              o_flash_dq_oe <= 1'b0;
              if (two_writes(op_r) && !second_r) begin
                second_r <= 1'b1;
                if (op_r == `FHC_OP_PROGRAM)
                  o_flash_dq_out <= data_r;
                else
                  o_flash_dq_out <= {8'h00, `FHC_CMD_CONFIRM};
                state_r <= ST_WRITE;
              end else if (op_r == `FHC_OP_RESUME || op_r == `FHC_OP_CLEAR) begin
                state_r <= ST_DONE;
              end else begin
                rd_cnt_r <= 2'h0;
                state_r  <= ST_READ;
              end
            end
          endcase
        end
        ST_READ: begin
          o_flash_ce_n <= 1'b0;
          o_flash_oe_n <= 1'b0;
          rd_cnt_r     <= rd_cnt_r + 2'h1;
          if (rd_cnt_r == RD_LAST) begin
            o_flash_ce_n <= 1'b1;
            o_flash_oe_n <= 1'b1;
            state_r      <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          o_status <= stat_w;
          if (!stat_w[`FHC_SB_READY] && op_r != `FHC_OP_STATUS) begin
            rd_cnt_r <= 2'h0;
            state_r  <= ST_READ;
          end else begin
            o_prog_fail    <= stat_w[`FHC_SB_PROG_FAIL];
            o_erase_fail   <= stat_w[`FHC_SB_ERASE_FAIL];
            o_supply_low   <= stat_w[`FHC_SB_SUPPLY_LOW] & ~marg_sync_r;
            o_lock_abort   <= stat_w[`FHC_SB_LOCK_ABORT];
            o_seq_err      <= seq_error(stat_w);
            o_prog_paused  <= stat_w[`FHC_SB_PROG_PAUSED];
            o_erase_paused <= stat_w[`FHC_SB_ERASE_PAUSED];
            state_r        <= ST_DONE;
          end
        end
        ST_DONE: begin
          o_done  <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> test/fhc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fhc_flash_model (
  input  wire logic        ce_n, oe_n, we_n, rst_n, fail, locked, vpp_low,
  input  wire logic [15:0] din,
  output logic      [15:0] dout
);
  logic [7:0] sr = 8'h80;
  logic [7:0] pend = 8'h00;
  logic [7:0] fb = 8'h00;
  logic [7:0] run = 8'h00;
  time        t_end = 0;
  // bit 0 reads 1, a released bus reads inverted
  assign dout = {8'h00, sr | 8'h01} ^ {16{ce_n | oe_n}};
  always #10 if (!sr[7] && $time >= t_end) sr = sr | fb | 8'h80;
  always @(posedge we_n or negedge rst_n) begin
    if (!rst_n) begin
      sr = 8'h80;
      pend = 8'h00;
    end else if (!ce_n && pend != 8'h00) begin
      if (locked) sr = sr | 8'h82;
      else if (vpp_low) sr = sr | 8'h88;
      else begin
        sr[7] = 1'b0;
        fb = fail ? pend : 8'h00;
        t_end = $time + 3000;
        run = pend;
      end
      pend = 8'h00;
    end else if (!ce_n) begin
      if (din[7:0] == 8'h50) sr = sr & 8'hC5;
      if (din[7:0] == 8'hB0 && !sr[7]) sr = sr | 8'h80 | (run == 8'h20 ? 8'h40 : 8'h04);
      if (din[7:0] == 8'hD0 && (sr[2] || sr[6])) sr = sr & 8'h3B;
      if (din[7:0] == 8'h10 || din[7:0] == 8'h20) pend = din[7:0];
    end
  end
endmodule
`default_nettype wire

// >>> test/fhc_host_props.sv
`timescale 1ns/10ps
`default_nettype none
module fhc_props (
  input wire logic       I_CLK, I_RST, i_cmd_valid, o_cmd_ready, o_done, o_cmd_bad, o_prog_fail,
  input wire logic       o_erase_fail, o_lock_abort, o_seq_err, o_prog_paused, o_erase_paused,
  input wire logic       o_flash_ce_n, o_flash_oe_n, o_flash_we_n,
  input wire logic [2:0] i_cmd_op,
  input wire logic [7:0] o_status
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_rd;
    (!o_flash_oe_n)[*3] ##1 o_flash_oe_n;
  endsequence
  sequence s_wr;
    !o_flash_ce_n ##1 o_flash_we_n ##1 o_flash_ce_n;
  endsequence
  AST_RD: assert property ($fell(o_flash_oe_n) |-> s_rd)
    else $error("read strobe");
  AST_WR: assert property ($fell(o_flash_we_n) |-> s_wr)
    else $error("write strobe");
  AST_BAD: assert property (i_cmd_valid && o_cmd_ready && i_cmd_op > 3'h5 |=> o_done && o_cmd_bad)
    else $error("not refused");
  AST_MASK: assert property (o_done |-> !o_status[0])
    else $error("bit 0 kept");
  AST_SEQ: assert property (o_done |-> o_seq_err == &{o_status[7], o_status[5:4]})
    else $error("seq flag");
  AST_FAIL: assert property (o_done && o_status[7] |-> {o_erase_fail, o_prog_fail} == o_status[5:4])
    else $error("fail flags");
  AST_LOCK: assert property (o_done |-> o_lock_abort == o_status[1])
    else $error("lock flag");
  AST_PAUSE: assert property (o_done |-> {o_erase_paused, o_prog_paused} == {o_status[6], o_status[2]})
    else $error("pause flags");
endmodule
bind fhc_host fhc_props u_fhc_props (.*);
`default_nettype wire

// >>> test/fhc_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fhc_host_tb;
  logic        I_CLK, I_RST, i_cmd_valid, i_supply_marginal, fail, locked, vpp_low, o_cmd_ready, o_done, tk;
  logic        o_cmd_bad, o_prog_fail, o_erase_fail, o_supply_low, o_lock_abort, o_seq_err, o_prog_paused;
  logic        o_erase_paused, o_flash_dq_oe, o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_rst_n;
  logic [2:0]  i_cmd_op;
  logic [21:0] i_cmd_addr, o_flash_addr;
  logic [15:0] i_cmd_data, i_flash_dq, o_flash_dq_out, mdq, lfsr;
  logic [7:0]  o_status, sticky, fl;
  logic [6:0]  cases [13] = '{7'h50, 7'h00, 7'h10, 7'h08, 7'h18, 7'h40, 7'h14, 7'h02, 7'h03, 7'h20, 7'h30, 7'h60, 7'h70};
  int          failures, samples_checked, n;
  assign i_flash_dq = o_flash_dq_oe ? o_flash_dq_out : mdq;
  fhc_host u_fhc_host (.*);
  fhc_flash_model u_fhc_flash_model (.ce_n(o_flash_ce_n), .oe_n(o_flash_oe_n), .we_n(o_flash_we_n),
    .rst_n(o_flash_rst_n), .fail(fail), .locked(locked), .vpp_low(vpp_low), .din(o_flash_dq_out), .dout(mdq));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] upd(input logic [7:0] s, input logic [2:0] c, input logic [3:0] k);
    if (c == 3'h4) return 8'h00;
    if (c > 3'h1) return s;
    return s | (k[2] ? 8'h02 : k[1] ? 8'h08 : k[3] ? {2'h0, c[0], !c[0], 4'h0} : 8'h00);
  endfunction
  task automatic chk(input string nm, input logic [21:0] seen, input logic [21:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("%0d checks, %0d mismatches", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic scen(input logic [2:0] c, input logic [3:0] k);
    @(posedge I_CLK) #1;
    lfsr = nx(lfsr);
    {fail, locked, vpp_low, i_supply_marginal} = k;
    {i_cmd_valid, i_cmd_op, i_cmd_addr, i_cmd_data} = {1'b1, c, lfsr[5:0], lfsr, ~lfsr};
    sticky = upd(sticky, c, k);
    fl = {&sticky[5:4], sticky[5:4], sticky[3] & !k[0], sticky[1], 3'h0};
    for (n = 0; n < 3000 && !o_done; n++) begin
      tk = o_cmd_ready;
      @(posedge I_CLK) #1;
      if (tk) i_cmd_valid = 1'b0;
    end
    chk("done", {7'h00, o_done}, 8'h01);
    chk("refused", {7'h00, o_cmd_bad}, {7'h00, c > 3'h5});
    if (c < 3'h3 || c == 3'h5) begin
      chk("status", o_status, 8'h80 | sticky);
      chk("flags", {o_seq_err, o_erase_fail, o_prog_fail, o_supply_low, o_lock_abort, o_prog_paused, o_erase_paused, 1'b0}, fl);
    end
    if (c < 3'h6) chk("addr", o_flash_addr, {lfsr[5:0], lfsr});
    if (c < 3'h2) chk("word", {6'h00, o_flash_dq_out}, c[0] ? 22'h0000D0 : {6'h00, ~lfsr});
    $display("op %0d knobs %h over", c, k);
  endtask
  initial begin
    I_CLK = 1'b0;
    forever #50 I_CLK = ~I_CLK;
  end
  initial begin
    #2000000;
    failures++;
    results();
  end
  initial begin
    I_RST = 1'b1;
    {i_cmd_valid, i_cmd_op, i_cmd_addr, i_cmd_data, i_supply_marginal, fail, locked, vpp_low, sticky} = '0;
    failures = 0;
    samples_checked = 0;
    lfsr = 16'h7F12;
    repeat (16) @(posedge I_CLK);
    #1 I_RST = 1'b0;
    foreach (cases[i]) scen(cases[i][6:4], cases[i][3:0]);
    repeat (16) begin
      lfsr = nx(lfsr);
      scen({lfsr[8] & lfsr[9], 1'b0, lfsr[0]}, {lfsr[1], lfsr[2] & lfsr[3], lfsr[4] & lfsr[5], lfsr[6]});
    end
    results();
  end
endmodule
`default_nettype wire
